// File: hdl/evd_top.sv
// Exception recognition, priority dispatch and register file
//
// What this block does
// - Either soft or hard reset input asserted takes system reset at offset 00100.
// - Transfer error acknowledge during a data bus transaction takes machine check at 00200.
// - A data access fault at 00300 sets the no-translation cause bit when no entry matched.
// - The protection cause bit is set when page or block protection forbids the access.
// - The I/O cause bit is set for special ops on I/O segments or external control ops on write-through.
// - The direction cause bit is set for a store and cleared for a load.
// - The breakpoint cause bit is set on an address match in any of three compare modes.
// - External control ops with the access enable cleared set a bit and fault.
// - An untranslatable fetch address takes instruction access at 00400.
// - A fetch from an I/O segment takes instruction access.
// - Keys with protection bits forbidding read take instruction access.
// - The external interrupt input takes external interrupt at 00500.
// - A floating-point operand in an I/O segment takes alignment at 00600.
// - A scalar operand crossing a page boundary takes alignment.
// - External interrupts are recognised only while the enable bit is set.
// - External interrupts wait until the pipeline and its exceptions have drained.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module evd_top (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_we,
  input  wire logic            reg_re,
  output logic      [31:0]     reg_rdata,
  input  wire logic            soft_reset_in,
  input  wire logic            hard_reset_in,
  input  wire logic            transfer_error_ack,
  input  wire logic            data_bus_busy,
  input  wire logic            ext_irq_in,
  input  wire logic            dacc_valid,
  input  wire logic            dacc_store,
  input  wire evd_pkg::evd_op_t dacc_op,
  input  wire logic [31:0]     dacc_ea,
  input  wire logic            segment_io_flag,
  input  wire logic            dacc_write_through,
  input  wire logic            dacc_xlate_miss,
  input  wire logic            dacc_prot_fault,
  input  wire logic            dacc_page_cross,
  input  wire logic            ifetch_valid,
  input  wire logic            ifetch_xlate_miss,
  input  wire logic            ifetch_io_seg,
  input  wire logic            ifetch_user,
  input  wire logic            supervisor_key,
  input  wire logic            user_key,
  input  wire logic [1:0]      page_protect_bits,
  input  wire logic            pipe_idle,
  input  wire logic            exc_ack,
  output logic                 exc_take,
  output logic      [19:0]     exc_vector,
  output var evd_pkg::evd_exc_t exc_kind,
  output logic                 exc_busy,
  output logic                 irq
);
  import evd_pkg::*;

  // ******************************************************
  // Helpers
  // ******************************************************
  function automatic logic [19:0] vec_of(input evd_exc_t k);
    case (k)
      EXC_RESET: vec_of = VEC_RESET;
      EXC_MCHK:  vec_of = VEC_MCHK;
      EXC_DACC:  vec_of = VEC_DACC;
      EXC_IACC:  vec_of = VEC_IACC;
      EXC_EXT:   vec_of = VEC_EXT;
      EXC_ALIGN: vec_of = VEC_ALIGN;
      default:   vec_of = 20'h00000;
    endcase
  endfunction

  function automatic logic [NUM_EXC-1:0] bit_of(input evd_exc_t k);
    case (k)
      EXC_RESET: bit_of = 6'h01;
      EXC_MCHK:  bit_of = 6'h02;
      EXC_DACC:  bit_of = 6'h04;
      EXC_IACC:  bit_of = 6'h08;
      EXC_EXT:   bit_of = 6'h10;
      EXC_ALIGN: bit_of = 6'h20;
      default:   bit_of = 6'h00;
    endcase
  endfunction

  // ******************************************************
  // Pin synchronisers
  // ******************************************************
  logic [4:0] pins_s;
  logic       soft_reset_in_s;
  logic       hard_reset_in_s;
  logic       tea_s;
  logic       busy_s;
  logic       ext_irq_s;

  evd_sync #(
    .WIDTH (5)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({ext_irq_in, data_bus_busy, transfer_error_ack, hard_reset_in, soft_reset_in}),
    .q     (pins_s)
  );

  assign soft_reset_in_s  = pins_s[0];
  assign hard_reset_in_s  = pins_s[1];
  assign tea_s     = pins_s[2];
  assign busy_s    = pins_s[3];
  assign ext_irq_s = pins_s[4];

  // ******************************************************
  // Registers
  // ******************************************************
  logic [31:0]        data_fault_cause_reg;
  logic [31:0]        data_breakpoint_reg;
  logic [1:0]         ctrl_r;
  logic [NUM_EXC-1:0] status_r;
  logic [NUM_EXC-1:0] mask_r;
  logic [31:0]        reg_rdata_r;
  logic               ext_access_enable_bit;
  logic               ext_irq_enable_bit;

  assign ext_access_enable_bit = ctrl_r[CTRL_EXT_ACC_BIT];
  assign ext_irq_enable_bit    = ctrl_r[CTRL_EXT_IRQ_BIT];

  // ******************************************************
  // Fault decoder
  // ******************************************************
  evd_fault_if fif ();

  assign fif.dacc_valid            = dacc_valid;
  assign fif.dacc_store            = dacc_store;
  assign fif.dacc_op               = dacc_op;
  assign fif.dacc_ea               = dacc_ea;
  assign fif.segment_io_flag       = segment_io_flag;
  assign fif.dacc_write_through    = dacc_write_through;
  assign fif.dacc_xlate_miss       = dacc_xlate_miss;
  assign fif.dacc_prot_fault       = dacc_prot_fault;
  assign fif.dacc_page_cross       = dacc_page_cross;
  assign fif.ext_access_enable_bit = ext_access_enable_bit;
  assign fif.data_breakpoint_reg   = data_breakpoint_reg;
  assign fif.ifetch_valid          = ifetch_valid;
  assign fif.ifetch_xlate_miss     = ifetch_xlate_miss;
  assign fif.ifetch_io_seg         = ifetch_io_seg;
  assign fif.ifetch_user           = ifetch_user;
  assign fif.supervisor_key        = supervisor_key;
  assign fif.user_key              = user_key;
  assign fif.page_protect_bits     = page_protect_bits;

  evd_fault_decode u_dec (
    .f (fif.decoder)
  );

  // ******************************************************
  // Asynchronous event capture
  // ******************************************************
  // Reset and machine check arrive from pins and may come while the
  // dispatcher is busy, so each is latched until it is dispatched.
  logic       rst_lvl_prev_r;
  logic       mchk_lvl_prev_r;
  logic       rst_pend_r;
  logic       mchk_pend_r;
  logic       rst_rise;
  logic       mchk_rise;
  logic       rst_lvl;
  logic       mchk_lvl;
  evd_exc_t   sel;
  evd_state_t state_r;
  logic       take_now;

  assign rst_lvl   = soft_reset_in_s || hard_reset_in_s;
  assign mchk_lvl  = tea_s && busy_s;
  assign rst_rise  = rst_lvl && !rst_lvl_prev_r;
  assign mchk_rise = mchk_lvl && !mchk_lvl_prev_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_lvl_prev_r  <= 1'b0;
      mchk_lvl_prev_r <= 1'b0;
    end else begin
      rst_lvl_prev_r  <= rst_lvl;
      mchk_lvl_prev_r <= mchk_lvl;
    end
  end

  // Set wins over the clear by dispatch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pend_r  <= 1'b0;
      mchk_pend_r <= 1'b0;
    end else begin
      rst_pend_r  <= rst_rise || (rst_pend_r && !(take_now && sel == EXC_RESET));
      mchk_pend_r <= mchk_rise || (mchk_pend_r && !(take_now && sel == EXC_MCHK));
    end
  end

  // ******************************************************
  // Priority select
  // ******************************************************
  // Reset, then machine check, then others
  always_comb begin
    sel = EXC_NONE;
    if (rst_pend_r) begin
      sel = EXC_RESET;
    end else if (mchk_pend_r) begin
      sel = EXC_MCHK;
    end else if (state_r == ST_IDLE) begin
      if (fif.iacc_fault) begin
        sel = EXC_IACC;
      end else if (fif.dacc_fault) begin
        sel = EXC_DACC;
      end else if (fif.align_fault) begin
        sel = EXC_ALIGN;
      end else if (ext_irq_s && ext_irq_enable_bit && pipe_idle && !dacc_valid &&
                   !ifetch_valid) begin
        sel = EXC_EXT;
      end
    end
  end

  // Catastrophic events may preempt a handler still waiting for acknowledge
  assign take_now = (sel != EXC_NONE);

  // ******************************************************
  // Dispatch state machine
  // ******************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take_now) begin
            state_r <= ST_WAIT_ACK;
          end
        end
        ST_WAIT_ACK: begin
          if (exc_ack && !take_now) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      exc_take   <= 1'b0;
      exc_vector <= 20'h00000;
      exc_kind   <= EXC_NONE;
    end else begin
      exc_take <= take_now;
      if (take_now) begin
        exc_vector <= vec_of(sel);
        exc_kind   <= sel;
      end
    end
  end

  assign exc_busy = (state_r == ST_WAIT_ACK);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_fault_cause_reg <= CAUSE_RESET;
    end else if (take_now && sel == EXC_DACC) begin
      data_fault_cause_reg <= fif.cause;
    end
  end

  // ******************************************************
  // Register writes
  // ******************************************************
  logic wr_bkpt;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;

  assign wr_bkpt   = reg_we && (reg_addr == ADDR_BKPT);
  assign wr_ctrl   = reg_we && (reg_addr == ADDR_CTRL);
  assign wr_status = reg_we && (reg_addr == ADDR_STATUS);
  assign wr_mask   = reg_we && (reg_addr == ADDR_MASK);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_breakpoint_reg <= BKPT_RESET;
    end else if (wr_bkpt) begin
      data_breakpoint_reg <= {reg_wdata[31:BKPT_ADDR_LSB], 1'b0, reg_wdata[1:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= MASK_RESET;
    end else if (wr_mask) begin
      mask_r <= reg_wdata[NUM_EXC-1:0];
    end
  end

  // ******************************************************
  // Interrupt status
  // ******************************************************
  // Write one to clear; a dispatch in the same cycle keeps its bit
  logic [NUM_EXC-1:0] status_clr;
  logic [NUM_EXC-1:0] status_set;

  assign status_clr = wr_status ? reg_wdata[NUM_EXC-1:0] : 6'h00;
  assign status_set = take_now ? bit_of(sel) : 6'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 6'h00;
    end else begin
      status_r <= (status_r & ~status_clr) | status_set;
    end
  end

  assign irq = |(status_r & mask_r);

  // ******************************************************
  // Register reads
  // ******************************************************
  // Data stand for one cycle only; unmapped addresses read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (reg_re) begin
      case (reg_addr)
        ADDR_CAUSE:  reg_rdata_r <= data_fault_cause_reg;
        ADDR_BKPT:   reg_rdata_r <= data_breakpoint_reg;
        ADDR_CTRL:   reg_rdata_r <= {30'h0, ctrl_r};
        ADDR_VECTOR: reg_rdata_r <= {9'h0, exc_kind, exc_vector};
        ADDR_STATUS: reg_rdata_r <= {26'h0, status_r};
        ADDR_MASK:   reg_rdata_r <= {26'h0, mask_r};
        default:     reg_rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata = reg_rdata_r;
endmodule
`default_nettype wire

// File: hdl/evd_pkg.sv
// Constants, register map and types of the exception vector dispatch block
package evd_pkg;
  // ******************************************************
  // Vector offsets
  // ******************************************************
  localparam logic [19:0] VEC_RESET = 20'h00100;
  localparam logic [19:0] VEC_MCHK  = 20'h00200;
  localparam logic [19:0] VEC_DACC  = 20'h00300;
  localparam logic [19:0] VEC_IACC  = 20'h00400;
  localparam logic [19:0] VEC_EXT   = 20'h00500;
  localparam logic [19:0] VEC_ALIGN = 20'h00600;
  // ******************************************************
  // Register byte addresses
  // ******************************************************
  localparam logic [7:0] ADDR_CAUSE  = 8'h00;
  localparam logic [7:0] ADDR_BKPT   = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_VECTOR = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  // ******************************************************
  // Field positions and reset values
  // ******************************************************
  localparam int CAUSE_NOTRANS_BIT = 30;
  localparam int CAUSE_PROT_BIT    = 27;
  localparam int CAUSE_IO_BIT      = 26;
  localparam int CAUSE_STORE_BIT   = 25;
  localparam int CAUSE_BKPT_BIT    = 22;
  localparam int CAUSE_EXTDIS_BIT  = 20;
  localparam int CTRL_EXT_ACC_BIT  = 0;
  localparam int CTRL_EXT_IRQ_BIT  = 1;
  localparam int BKPT_ADDR_LSB     = 3;
  localparam int NUM_EXC           = 6;
  localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
  localparam logic [31:0] BKPT_RESET  = 32'h0000_0000;
  localparam logic [1:0]  CTRL_RESET  = 2'h0;
  localparam logic [5:0]  MASK_RESET  = 6'h00;
  localparam logic [1:0]  BKPT_OFF    = 2'h0;
  localparam logic [1:0]  BKPT_LOAD   = 2'h1;
  localparam logic [1:0]  BKPT_STORE  = 2'h2;
  localparam logic [1:0]  PP_NO_ACCESS = 2'h0;
  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic [2:0] {
    EXC_NONE, EXC_RESET, EXC_MCHK, EXC_DACC, EXC_IACC, EXC_EXT, EXC_ALIGN
  } evd_exc_t;
  typedef enum logic [2:0] {
    OP_PLAIN, OP_EXT_CTRL_IN_WORD, OP_EXT_CTRL_OUT_WORD, OP_LOAD_RESERVE_WORD,
    OP_STORE_COND_WORD, OP_LOAD_STRING_CMP_BYTE, OP_FLOAT
  } evd_op_t;
  typedef enum {ST_IDLE, ST_WAIT_ACK} evd_state_t;
endpackage

// File: hdl/evd_fault_if.sv
// Access attributes and decoded fault causes between dispatcher and decoder
`timescale 1ns/1ns
`default_nettype none
interface evd_fault_if;
  import evd_pkg::*;
  logic        dacc_valid;
  logic        dacc_store;
  evd_op_t     dacc_op;
  logic [31:0] dacc_ea;
  logic        segment_io_flag;
  logic        dacc_write_through;
  logic        dacc_xlate_miss;
  logic        dacc_prot_fault;
  logic        dacc_page_cross;
  logic        ext_access_enable_bit;
  logic [31:0] data_breakpoint_reg;
  logic        ifetch_valid;
  logic        ifetch_xlate_miss;
  logic        ifetch_io_seg;
  logic        ifetch_user;
  logic        supervisor_key;
  logic        user_key;
  logic [1:0]  page_protect_bits;
  logic        dacc_fault;
  logic        align_fault;
  logic        iacc_fault;
  logic [31:0] cause;
  modport decoder (
    input  dacc_valid, dacc_store, dacc_op, dacc_ea, segment_io_flag, dacc_write_through,
    input  dacc_xlate_miss, dacc_prot_fault, dacc_page_cross, ext_access_enable_bit,
    input  data_breakpoint_reg, ifetch_valid, ifetch_xlate_miss, ifetch_io_seg,
    input  ifetch_user, supervisor_key, user_key, page_protect_bits,
    output dacc_fault, align_fault, iacc_fault, cause
  );
  modport owner (
    output dacc_valid, dacc_store, dacc_op, dacc_ea, segment_io_flag, dacc_write_through,
    output dacc_xlate_miss, dacc_prot_fault, dacc_page_cross, ext_access_enable_bit,
    output data_breakpoint_reg, ifetch_valid, ifetch_xlate_miss, ifetch_io_seg,
    output ifetch_user, supervisor_key, user_key, page_protect_bits,
    input  dacc_fault, align_fault, iacc_fault, cause
  );
endinterface
`default_nettype wire

// File: hdl/evd_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module evd_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: hdl/evd_fault_decode.sv
// Combinational decode of data, fetch and alignment fault causes
`timescale 1ns/1ns
`default_nettype none
module evd_fault_decode (
  evd_fault_if.decoder f
);
  import evd_pkg::*;
  logic ext_op;
  logic io_class_op;
  logic bkpt_hit;
  logic cur_key;
  logic [31:0] c;
  always_comb begin
    ext_op      = (f.dacc_op == OP_EXT_CTRL_IN_WORD) || (f.dacc_op == OP_EXT_CTRL_OUT_WORD);
    io_class_op = ext_op || (f.dacc_op == OP_LOAD_RESERVE_WORD) ||
                  (f.dacc_op == OP_STORE_COND_WORD) || (f.dacc_op == OP_LOAD_STRING_CMP_BYTE);
    bkpt_hit    = (f.data_breakpoint_reg[1:0] != BKPT_OFF) &&
                  (f.dacc_ea[31:BKPT_ADDR_LSB] == f.data_breakpoint_reg[31:BKPT_ADDR_LSB]) &&
                  (f.dacc_store ? f.data_breakpoint_reg[1] : f.data_breakpoint_reg[0]);
    c = 32'h0000_0000;
    c[CAUSE_NOTRANS_BIT] = f.dacc_xlate_miss;
    c[CAUSE_PROT_BIT]    = f.dacc_prot_fault;
    c[CAUSE_IO_BIT]      = (io_class_op && f.segment_io_flag) ||
                           (ext_op && f.dacc_write_through);
    c[CAUSE_STORE_BIT]   = f.dacc_store;
    c[CAUSE_BKPT_BIT]    = bkpt_hit;
    c[CAUSE_EXTDIS_BIT]  = ext_op && !f.ext_access_enable_bit;
    f.cause = c;
    // Direction bit alone never raises the fault
    f.dacc_fault = f.dacc_valid && (c[CAUSE_NOTRANS_BIT] || c[CAUSE_PROT_BIT] ||
                   c[CAUSE_IO_BIT] || c[CAUSE_BKPT_BIT] || c[CAUSE_EXTDIS_BIT]);
    // Float in I/O or non-float page cross
    f.align_fault = f.dacc_valid && (((f.dacc_op == OP_FLOAT) && f.segment_io_flag) ||
                    ((f.dacc_op != OP_FLOAT) && f.dacc_page_cross));
    cur_key = f.ifetch_user ? f.user_key : f.supervisor_key;
    f.iacc_fault = f.ifetch_valid && (f.ifetch_xlate_miss || f.ifetch_io_seg ||
                   (cur_key && (f.page_protect_bits == PP_NO_ACCESS)));
  end
endmodule
`default_nettype wire

// File: verif/evd_partner.sv
// Bus logic and interrupt source facing the dispatcher
`timescale 1ns/1ns
`default_nettype none
module evd_partner (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [4:0] req,
  input  wire logic       slow,
  input  wire logic       exc_busy,
  output logic      [4:0] pins,
  output logic            exc_ack
);
  logic [2:0] wait_r;
  // ****
  // Pins
  // ****
  // Pins move one edge after a request, like registered board logic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= 5'h00;
    end else begin
      pins <= req;
    end
  end
  // ****
  // Acknowledge
  // ****
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 3'h0;
    end else begin
      wait_r <= exc_busy ? wait_r + 3'h1 : 3'h0;
    end
  end
  // Slow mode gives a level interrupt time to fall before release
  assign exc_ack = exc_busy && (!slow || wait_r == 3'h5);
endmodule
`default_nettype wire

// File: verif/evd_assertions.sv
// Port-level checks for the exception vector dispatcher
`timescale 1ns/1ns
`default_nettype none
module evd_assertions
  import evd_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              exc_take,
  input wire logic [19:0]       exc_vector,
  input wire evd_pkg::evd_exc_t exc_kind,
  input wire logic              exc_busy,
  input wire logic              exc_ack,
  input wire logic              pipe_idle,
  input wire logic              dacc_valid,
  input wire logic              dacc_xlate_miss,
  input wire logic              ifetch_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****
  // Vector per kind
  // ****
  a_reset_vector: assert property (exc_take && exc_kind == EXC_RESET |->
    exc_vector == VEC_RESET) else $error("reset vector wrong");
  a_mchk_vector: assert property (exc_take && exc_kind == EXC_MCHK |->
    exc_vector == VEC_MCHK) else $error("machine check vector wrong");
  a_dacc_vector: assert property (exc_take && exc_kind == EXC_DACC |->
    exc_vector == VEC_DACC) else $error("data access vector wrong");
  a_iacc_vector: assert property (exc_take && exc_kind == EXC_IACC |->
    exc_vector == VEC_IACC) else $error("fetch access vector wrong");
  a_ext_vector: assert property (exc_take && exc_kind == EXC_EXT |->
    exc_vector == VEC_EXT) else $error("external vector wrong");
  a_align_vector: assert property (exc_take && exc_kind == EXC_ALIGN |->
    exc_vector == VEC_ALIGN) else $error("alignment vector wrong");
  // ****
  // Dispatch timing
  // ****
  a_dacc_taken: assert property (dacc_valid && dacc_xlate_miss && !ifetch_valid &&
    !exc_busy && !exc_take |=> exc_take && exc_kind == EXC_DACC) else $error("fault missed");
  a_ext_drained: assert property (exc_take && exc_kind == EXC_EXT |-> $past(pipe_idle))
    else $error("interrupt taken while pipe busy");
  a_busy_follows: assert property (exc_take |-> exc_busy)
    else $error("busy missing after dispatch");
  a_busy_holds: assert property (exc_busy && !exc_ack && !exc_take |=> exc_busy)
    else $error("busy dropped before ack");
endmodule
bind evd_top evd_assertions u_chk (.mclk, .rst_n, .exc_take, .exc_vector, .exc_kind,
  .exc_busy, .exc_ack, .pipe_idle, .dacc_valid, .dacc_xlate_miss, .ifetch_valid);
`default_nettype wire

// File: verif/test_exception_vector_dispatch.sv
// Self-checking bench for the exception vector dispatcher
`timescale 1ns/1ns
`default_nettype none
module test_exception_vector_dispatch;
  import evd_pkg::*;
  localparam logic [31:0] NT = 32'h1 << CAUSE_NOTRANS_BIT, PR = 32'h1 << CAUSE_PROT_BIT;
  localparam logic [31:0] IO = 32'h1 << CAUSE_IO_BIT, ST = 32'h1 << CAUSE_STORE_BIT;
  localparam logic [31:0] BK = 32'h1 << CAUSE_BKPT_BIT, XD = 32'h1 << CAUSE_EXTDIS_BIT;
  logic        mclk = 1'b0, rst_n = 1'b0, reg_we = 1'b0, reg_re = 1'b0, slow = 1'b0;
  logic        dacc_valid = 1'b0, ifetch_valid = 1'b0, pipe_idle = 1'b1;
  logic        exc_ack, exc_take, exc_busy, irq;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, dacc_ea = 32'h1004, reg_rdata, d;
  logic [4:0]  req = 5'h00, pins;
  logic [6:0]  fv = 7'h00;
  logic [19:0] exc_vector;
  evd_op_t     dacc_op = OP_PLAIN;
  evd_exc_t    exc_kind;
  int          error_cnt = 0, checks = 0, takes = 0;
  always #20 mclk = ~mclk;
  always @(negedge mclk) if (exc_take === 1'b1) takes++;
  // Shared field vector: only the raised valid gives its bits meaning
  evd_top DUT (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .soft_reset_in(pins[3]), .hard_reset_in(pins[4]), .transfer_error_ack(pins[0]),
    .data_bus_busy(pins[1]), .ext_irq_in(pins[2]), .dacc_valid, .dacc_store(fv[5]),
    .dacc_op, .dacc_ea, .segment_io_flag(fv[4]), .dacc_write_through(fv[3]),
    .dacc_xlate_miss(fv[2]), .dacc_prot_fault(fv[1]), .dacc_page_cross(fv[0]),
    .ifetch_valid, .ifetch_xlate_miss(fv[6]), .ifetch_io_seg(fv[5]), .ifetch_user(fv[4]),
    .supervisor_key(fv[3]), .user_key(fv[2]), .page_protect_bits(fv[1:0]), .pipe_idle,
    .exc_ack, .exc_take, .exc_vector, .exc_kind, .exc_busy, .irq);
  evd_partner PTR (.mclk, .rst_n, .req, .slow, .exc_busy, .pins, .exc_ack);
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic quiet(input int n);
    int t0;
    t0 = takes;
    repeat (n) @(posedge mclk);
    chk(takes - t0, 0);
  endtask
  task automatic wt(input evd_exc_t k, input logic [19:0] v);
    for (int i = 0; i < 12 && exc_take !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(exc_take, 1'b1);
    chk(exc_kind, k);
    chk(exc_vector, v);
  endtask
  task automatic idle();
    for (int i = 0; i < 20 && exc_busy !== 1'b0; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic pw(input logic [4:0] r, input evd_exc_t k, input logic [19:0] v);
    @(posedge mclk);
    req <= r;
    repeat (3) @(posedge mclk);
    req <= 5'h00;
    if (k == EXC_NONE) quiet(10);
    else wt(k, v);
    idle();
  endtask
  task automatic core(input logic i, input evd_op_t op, input logic [6:0] f,
                      input evd_exc_t k, input logic [19:0] v, input logic [31:0] c);
    @(posedge mclk);
    {ifetch_valid, dacc_valid} <= {i, !i};
    dacc_op <= op;
    fv <= f;
    @(posedge mclk);
    {ifetch_valid, dacc_valid} <= 2'b00;
    #1;
    if (k == EXC_NONE) quiet(4);
    else wt(k, v);
    rd(ADDR_CAUSE);
    chk(d, c);
    idle();
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reg();
    chk(irq, 1'b0);
    for (int a = 0; a < 24; a += 4) begin
      rd(8'(a));
      chk(d, 32'h0);
    end
    wr(ADDR_VECTOR, 32'hffff_ffff);
    rd(ADDR_VECTOR);
    chk(d, 32'h0);
  endtask
  task automatic t_pins();
    pw(5'h08, EXC_RESET, VEC_RESET);
    pw(5'h10, EXC_RESET, VEC_RESET);
    pw(5'h01, EXC_NONE, VEC_MCHK);
    pw(5'h03, EXC_MCHK, VEC_MCHK);
    pw(5'h13, EXC_RESET, VEC_RESET);
    idle();
    rd(ADDR_VECTOR);
    chk(d, {9'h000, EXC_MCHK, VEC_MCHK});
  endtask
  task automatic t_core();
    wr(ADDR_CTRL, 32'h1);
    core(0, OP_PLAIN, 7'h04, EXC_DACC, VEC_DACC, NT);
    core(0, OP_PLAIN, 7'h22, EXC_DACC, VEC_DACC, PR | ST);
    for (int i = 1; i < 6; i++) core(0, evd_op_t'(i), 7'h10, EXC_DACC, VEC_DACC, IO);
    core(0, OP_EXT_CTRL_OUT_WORD, 7'h08, EXC_DACC, VEC_DACC, IO);
    core(0, OP_PLAIN, 7'h10, EXC_NONE, VEC_DACC, IO);
    core(0, OP_PLAIN, 7'h20, EXC_NONE, VEC_DACC, IO);
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_BKPT, 32'h1000 | m);
      core(0, OP_PLAIN, 7'(m == 2) << 5, EXC_DACC, VEC_DACC, BK | ST * (m == 2));
    end
    wr(ADDR_BKPT, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    core(0, OP_EXT_CTRL_IN_WORD, 7'h00, EXC_DACC, VEC_DACC, XD);
    core(0, OP_FLOAT, 7'h10, EXC_ALIGN, VEC_ALIGN, XD);
    core(0, OP_PLAIN, 7'h01, EXC_ALIGN, VEC_ALIGN, XD);
    core(0, OP_PLAIN, 7'h05, EXC_DACC, VEC_DACC, NT);
    core(1, OP_PLAIN, 7'h40, EXC_IACC, VEC_IACC, NT);
    core(1, OP_PLAIN, 7'h20, EXC_IACC, VEC_IACC, NT);
    core(1, OP_PLAIN, 7'h08, EXC_IACC, VEC_IACC, NT);
    core(1, OP_PLAIN, 7'h14, EXC_IACC, VEC_IACC, NT);
    core(1, OP_PLAIN, 7'h09, EXC_NONE, VEC_IACC, NT);
  endtask
  task automatic t_ext();
    @(posedge mclk);
    slow <= 1'b1;
    req <= 5'h04;
    quiet(8);
    pipe_idle <= 1'b0;
    wr(ADDR_CTRL, 32'h2);
    quiet(8);
    @(posedge mclk);
    pipe_idle <= 1'b1;
    wt(EXC_EXT, VEC_EXT);
    @(posedge mclk);
    req <= 5'h00;
    wr(ADDR_CTRL, 32'h0);
    idle();
    slow <= 1'b0;
  endtask
  task automatic t_irq();
    rd(ADDR_STATUS);
    chk(d, 32'h3f);
    wr(ADDR_MASK, 32'h4);
    #1 chk(irq, 1'b1);
    wr(ADDR_STATUS, 32'h4);
    #1 chk(irq, 1'b0);
    rd(ADDR_STATUS);
    chk(d, 32'h3b);
    rd(8'h40);
    chk(d, 32'h0);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_reg();
    t_pins();
    t_core();
    t_ext();
    t_irq();
    conclude();
  end
  // Whole run is well under 3000 cycles
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
